/* File: tcct_pin_model.sv */
`timescale 1ns/1ps
module tcct_pin_model (
   input wire logic clk,
   input tcct_pkg::tcct_pins_t pins,
   input wire logic ev0,
   input wire logic ev1,
   output logic ch0_in,
   output logic ch1_in,
   output logic ext_clk
);
   import tcct_pkg::*;
   initial ext_clk = 1'b0;
   // Driven pin wins; otherwise the event source sets the level
   assign ch0_in = pins.oe[0] ? pins.out[0] : ev0;
   assign ch1_in = pins.oe[1] ? pins.out[1] : ev1;

   // Two cycles high, two low: each phase outlasts the input sync
   task automatic ext_burst(input int n);
      repeat (n) begin
         @(posedge clk);
         ext_clk <= 1'b1;
         repeat (2) @(posedge clk);
         ext_clk <= 1'b0;
         @(posedge clk);
      end
   endtask : ext_burst
endmodule : tcct_pin_model

/* File: tcct_pkg.sv */
package tcct_pkg;
   localparam int CNT_W = 16;
   localparam int DIV_W = 7;
   localparam int IDX_W = 6;
   localparam int ADDR_W = 8;
   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_STATUS_CTRL = 6'h0a;
   localparam logic [IDX_W-1:0] IDX_CNT_HI = 6'h0c;
   localparam logic [IDX_W-1:0] IDX_CNT_LO = 6'h0d;
   localparam logic [IDX_W-1:0] IDX_MOD_HI = 6'h0e;
   localparam logic [IDX_W-1:0] IDX_MOD_LO = 6'h0f;
   localparam logic [IDX_W-1:0] IDX_CH0_CTRL = 6'h10;
   localparam logic [IDX_W-1:0] IDX_CH0_HI = 6'h11;
   localparam logic [IDX_W-1:0] IDX_CH0_LO = 6'h12;
   localparam logic [IDX_W-1:0] IDX_CH1_CTRL = 6'h13;
   localparam logic [IDX_W-1:0] IDX_CH1_HI = 6'h14;
   localparam logic [IDX_W-1:0] IDX_CH1_LO = 6'h15;
   // timer_status_control fields
   localparam int B_OVF = 7;
   localparam int B_OVF_IE = 6;
   localparam int B_HALT = 5;
   localparam int B_CRST = 4;
   localparam int B_PS_MSB = 2;
   // chanN_status_control fields
   localparam int B_EVT = 7;
   localparam int B_IE = 6;
   localparam int B_BUF = 5;
   localparam int B_MODE = 4;
   localparam int B_ELS_HI = 3;
   localparam int B_ELS_LO = 2;
   localparam int B_WRAP_TGL = 1;
   localparam int B_FULL = 0;
   localparam logic [7:0] STATUS_CTRL_RST = 8'h20;
   localparam logic [7:0] STATUS_CTRL_WMASK = 8'h67;
   localparam logic [CNT_W-1:0] MOD_RST = 16'hffff;
   localparam logic [7:0] CH0_WMASK = 8'h7f;
   localparam logic [7:0] CH1_WMASK = 8'h5f;
   localparam logic [2:0] PS_EXT = 3'h7;
   localparam logic [1:0] ELS_OFF = 2'h0;
   localparam logic [1:0] ELS_RISE = 2'h1;
   localparam logic [1:0] ELS_FALL = 2'h2;
   localparam logic [1:0] ELS_BOTH = 2'h3;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } tcct_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tcct_axi_rsp_t;

   typedef struct packed {
      logic [1:0] out;
      logic [1:0] oe;
   } tcct_pins_t;
endpackage : tcct_pkg

/* File: tcct_timer.sv */
`timescale 1ns/1ps
// Operation
// - One 16-bit up-counter, free-running or wrapping at a modulo limit.
// - Modulo limit high and low bytes set the wrap value.
// - Reading counter bytes gives live count and never disturbs counting.
// - Each channel chooses input capture or output compare; buffered select forces channel 0 to compare and idles channel 1.
// - Seven bus clock rates or the external clock pin drive the counter.
// - Low three bits of status control select the count source.
// - Capture triggers on rising, falling or either edge as configured.
// - Compare event sets, clears or inverts the channel pin.
// - Toggle-on-wrap bit inverts the channel pin at each overflow.
// - Halt bit resets to one; counter reset bit reads as zero.
// - Channel 0 control holds flag, enable, modes, edges, wrap toggle, full duty.
// - Channel 1 control matches channel 0 but bit 5 reads zero.
// - Modulo limit resets to all ones, full 16-bit span.
// - Active capture edge latches the counter into the channel value.
// - Counter equal to compare value applies the channel pin action.
// - Buffered select links channels; last written value takes over at overflow.
// - In PWM use the pin toggles at the modulo limit, setting the period.
module tcct_timer (
   input wire logic CLK,
   input wire logic RST,
   input tcct_pkg::tcct_axi_req_t AXI_REQ,
   output tcct_pkg::tcct_axi_rsp_t AXI_RSP,
   input wire logic CH0_PIN_IN,
   input wire logic CH1_PIN_IN,
   input wire logic EXT_COUNT_CLOCK_PIN,
   output tcct_pkg::tcct_pins_t PINS,
   output logic TIMER_IRQ
);
   import tcct_pkg::*;

   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [2:0] sync3;
      logic [DIV_W-1:0] div;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] mod;
      logic [7:0] ctrl;
      logic [1:0][7:0] chctl;
      logic [1:0][CNT_W-1:0] val;
      logic [2:0] armed;
      logic active_ch;
      logic last_wr_ch;
      logic [1:0] pin_out;
      logic [1:0] pin_oe;
      logic aw_held;
      logic [ADDR_W-1:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } tcct_state_t;

   tcct_state_t st_reg;
   tcct_state_t st_next;
   logic awready;
   logic wready;
   logic arready;

   assign awready = !st_reg.aw_held && !st_reg.bvalid;
   assign wready = !st_reg.w_held && !st_reg.bvalid;
   assign arready = !st_reg.rvalid;

   assign AXI_RSP = '{
      awready: awready,
      wready: wready,
      bvalid: st_reg.bvalid,
      bresp: st_reg.bresp,
      arready: arready,
      rvalid: st_reg.rvalid,
      rdata: {24'h000000, st_reg.rdata},
      rresp: st_reg.rresp
   };

   assign PINS = '{out: st_reg.pin_out, oe: st_reg.pin_oe};

   // Request level from flags and their enables
   assign TIMER_IRQ = (st_reg.ctrl[B_OVF] && st_reg.ctrl[B_OVF_IE])
      || (st_reg.chctl[0][B_EVT] && st_reg.chctl[0][B_IE])
      || (st_reg.chctl[1][B_EVT] && st_reg.chctl[1][B_IE]);

   always_comb begin
      tcct_state_t n;
      logic [DIV_W-1:0] mask;
      logic [2:0] rise;
      logic [2:0] fall;
      logic [IDX_W-1:0] widx;
      logic [IDX_W-1:0] ridx;
      logic [7:0] d;
      logic [7:0] rv;
      logic [1:0] els;
      logic [CNT_W-1:0] cmp;
      logic tick;
      logic ovf;
      logic crst;
      logic hit;
      logic buffered;
      logic outm;
      logic edg;
      logic chon;
      n = st_reg;
      mask = '0;
      rise = '0;
      fall = '0;
      widx = '0;
      ridx = '0;
      d = '0;
      rv = '0;
      els = '0;
      cmp = '0;
      tick = 1'b0;
      ovf = 1'b0;
      crst = 1'b0;
      hit = 1'b0;
      buffered = 1'b0;
      outm = 1'b0;
      edg = 1'b0;
      chon = 1'b0;

      // Pins: bit 0 external clock, bits 1 and 2 channel pins
      n.sync1 = {CH1_PIN_IN, CH0_PIN_IN, EXT_COUNT_CLOCK_PIN};
      n.sync2 = st_reg.sync1;
      n.sync3 = st_reg.sync2;
      rise = st_reg.sync2 & ~st_reg.sync3;
      fall = ~st_reg.sync2 & st_reg.sync3;

      // Bus address and data phases, taken in either order
      if (AXI_REQ.awvalid && awready) begin
         n.aw_held = 1'b1;
         n.awaddr = AXI_REQ.awaddr;
      end
      if (AXI_REQ.wvalid && wready) begin
         n.w_held = 1'b1;
         n.wdata = AXI_REQ.wdata;
         n.wstrb = AXI_REQ.wstrb;
      end
      if (st_reg.bvalid && AXI_REQ.bready) begin
         n.bvalid = 1'b0;
      end
      if (st_reg.rvalid && AXI_REQ.rready) begin
         n.rvalid = 1'b0;
      end

      if (st_reg.aw_held && st_reg.w_held) begin
         widx = st_reg.awaddr[ADDR_W-1:2];
         d = st_reg.wdata[7:0];
         hit = 1'b1;
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.bvalid = 1'b1;
         if (st_reg.wstrb[0]) begin
            case (widx)
               IDX_STATUS_CTRL: begin
                  n.ctrl = (st_reg.ctrl & ~STATUS_CTRL_WMASK) | (d & STATUS_CTRL_WMASK);
                  if (!d[B_OVF] && st_reg.armed[0]) begin
                     n.ctrl[B_OVF] = 1'b0;
                     n.armed[0] = 1'b0;
                  end
                  crst = d[B_CRST];
               end
               IDX_MOD_HI: n.mod[15:8] = d;
               IDX_MOD_LO: n.mod[7:0] = d;
               IDX_CH0_CTRL: begin
                  n.chctl[0] = (st_reg.chctl[0] & ~CH0_WMASK) | (d & CH0_WMASK);
                  if (!d[B_EVT] && st_reg.armed[1]) begin
                     n.chctl[0][B_EVT] = 1'b0;
                     n.armed[1] = 1'b0;
                  end
               end
               IDX_CH1_CTRL: begin
                  n.chctl[1] = (st_reg.chctl[1] & ~CH1_WMASK) | (d & CH1_WMASK);
                  if (!d[B_EVT] && st_reg.armed[2]) begin
                     n.chctl[1][B_EVT] = 1'b0;
                     n.armed[2] = 1'b0;
                  end
               end
               IDX_CH0_HI: begin
                  n.val[0][15:8] = d;
                  n.last_wr_ch = 1'b0;
               end
               IDX_CH0_LO: begin
                  n.val[0][7:0] = d;
                  n.last_wr_ch = 1'b0;
               end
               IDX_CH1_HI: begin
                  n.val[1][15:8] = d;
                  n.last_wr_ch = 1'b1;
               end
               IDX_CH1_LO: begin
                  n.val[1][7:0] = d;
                  n.last_wr_ch = 1'b1;
               end
               // Counter bytes ignore writes
               IDX_CNT_HI, IDX_CNT_LO: hit = 1'b1;
               default: hit = 1'b0;
            endcase
         end else begin
            hit = (widx >= IDX_STATUS_CTRL) && (widx <= IDX_CH1_LO)
               && (widx != IDX_STATUS_CTRL + 6'h01);
         end
         n.bresp = hit ? RESP_OKAY : RESP_SLVERR;
      end

      if (AXI_REQ.arvalid && arready) begin
         ridx = AXI_REQ.araddr[ADDR_W-1:2];
         hit = 1'b1;
         case (ridx)
            IDX_STATUS_CTRL: begin
               rv = st_reg.ctrl; // counter reset bit never stored
               if (st_reg.ctrl[B_OVF]) begin
                  n.armed[0] = 1'b1;
               end
            end
            IDX_CNT_HI: rv = st_reg.cnt[15:8];
            IDX_CNT_LO: rv = st_reg.cnt[7:0];
            IDX_MOD_HI: rv = st_reg.mod[15:8];
            IDX_MOD_LO: rv = st_reg.mod[7:0];
            IDX_CH0_CTRL: begin
               rv = st_reg.chctl[0];
               if (st_reg.chctl[0][B_EVT]) begin
                  n.armed[1] = 1'b1;
               end
            end
            IDX_CH1_CTRL: begin
               rv = st_reg.chctl[1];
               if (st_reg.chctl[1][B_EVT]) begin
                  n.armed[2] = 1'b1;
               end
            end
            IDX_CH0_HI: rv = st_reg.val[0][15:8];
            IDX_CH0_LO: rv = st_reg.val[0][7:0];
            IDX_CH1_HI: rv = st_reg.val[1][15:8];
            IDX_CH1_LO: rv = st_reg.val[1][7:0];
            default: hit = 1'b0;
         endcase
         n.rvalid = 1'b1;
         n.rdata = rv;
         n.rresp = hit ? RESP_OKAY : RESP_SLVERR;
      end

      // Count clock: divide by 2^select, or the synchronised pin edge
      mask = DIV_W'((8'h01 << st_reg.ctrl[B_PS_MSB:0]) - 8'h01);
      if (st_reg.ctrl[B_PS_MSB:0] == PS_EXT) begin
         tick = rise[0];
      end else begin
         tick = (st_reg.div & mask) == mask;
      end
      if (st_reg.ctrl[B_HALT] || crst) begin
         tick = 1'b0;
      end
      if (crst) begin
         n.cnt = '0;
         n.div = '0;
      end else if (!st_reg.ctrl[B_HALT]) begin
         n.div = st_reg.div + DIV_W'(1);
      end
      ovf = tick && (st_reg.cnt == st_reg.mod);
      if (tick) begin
         n.cnt = ovf ? '0 : st_reg.cnt + CNT_W'(1);
      end
      if (ovf) begin
         n.ctrl[B_OVF] = 1'b1;
      end

      buffered = st_reg.chctl[0][B_BUF];
      if (ovf && buffered) begin
         n.active_ch = st_reg.last_wr_ch;
      end else if (!buffered) begin
         n.active_ch = 1'b0;
      end

      for (int i = 0; i < 2; i++) begin
         // Channel 1 is idle while linked to channel 0
         chon = (i == 0) || !buffered;
         outm = st_reg.chctl[i][B_MODE] || ((i == 0) && buffered);
         els = st_reg.chctl[i][B_ELS_HI:B_ELS_LO];
         cmp = ((i == 0) && buffered) ? st_reg.val[st_reg.active_ch] : st_reg.val[i];
         n.pin_oe[i] = chon && outm && (els != ELS_OFF);
         if (chon && !outm) begin
            case (els)
               ELS_RISE: edg = rise[i+1];
               ELS_FALL: edg = fall[i+1];
               ELS_BOTH: edg = rise[i+1] | fall[i+1];
               default: edg = 1'b0;
            endcase
            if (edg) begin
               n.val[i] = st_reg.cnt;
               n.chctl[i][B_EVT] = 1'b1;
            end
         end else if (chon) begin
            // Full duty suppresses the compare pin action, not the flag, so the pin stays at its wrap level
            if (tick && (st_reg.cnt == cmp)) begin
               n.chctl[i][B_EVT] = 1'b1;
               if (!st_reg.chctl[i][B_FULL]) begin
                  case (els)
                     ACT_TOGGLE: n.pin_out[i] = !st_reg.pin_out[i];
                     ACT_CLEAR: n.pin_out[i] = 1'b0;
                     ACT_SET: n.pin_out[i] = 1'b1;
                     default: n.pin_out[i] = st_reg.pin_out[i];
                  endcase
               end
            end
            if (ovf && st_reg.chctl[i][B_WRAP_TGL]) begin
               n.pin_out[i] = !n.pin_out[i];
            end
         end
      end
      st_next = n;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_reg <= '0;
         st_reg.ctrl <= STATUS_CTRL_RST;
         st_reg.mod <= MOD_RST;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : tcct_timer

/* File: tcct_timer_assertions.sv */
`timescale 1ns/1ps
module tcct_timer_assertions (
   input wire logic CLK,
   input wire logic RST,
   input tcct_pkg::tcct_axi_req_t AXI_REQ,
   input tcct_pkg::tcct_axi_rsp_t AXI_RSP,
   input wire logic CH0_PIN_IN,
   input wire logic CH1_PIN_IN,
   input wire logic EXT_COUNT_CLOCK_PIN,
   input tcct_pkg::tcct_pins_t PINS,
   input wire logic TIMER_IRQ
);
   import tcct_pkg::*;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);

   sequence wr_taken;
      AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready;
   endsequence
   sequence rd_taken;
      AXI_REQ.arvalid && AXI_RSP.arready;
   endsequence
   sequence rd_at(logic [5:0] idx);
      rd_taken ##0 (AXI_REQ.araddr[7:2] == idx);
   endsequence

   wr_answer_a: assert property (wr_taken |=> !AXI_RSP.bvalid ##1 AXI_RSP.bvalid)
      else $error("write answer late or early");
   rd_answer_a: assert property (rd_taken |=> AXI_RSP.rvalid)
      else $error("read answer missing");
   bvalid_drop_a: assert property (AXI_RSP.bvalid && AXI_REQ.bready |=> !AXI_RSP.bvalid)
      else $error("write answer not retired");
   rvalid_drop_a: assert property (AXI_RSP.rvalid && AXI_REQ.rready |=> !AXI_RSP.rvalid)
      else $error("read answer not retired");
   rd_block_a: assert property (AXI_RSP.rvalid |-> !AXI_RSP.arready)
      else $error("read accepted while answer pending");
   wr_block_a: assert property (AXI_RSP.bvalid |-> !AXI_RSP.awready && !AXI_RSP.wready)
      else $error("write accepted while answer pending");
   rdata_width_a: assert property (AXI_RSP.rvalid |-> AXI_RSP.rdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   unmapped_err_a: assert property (rd_at(6'h03) |=> AXI_RSP.rresp == RESP_SLVERR)
      else $error("unmapped read not refused");
   crst_zero_a: assert property (rd_at(IDX_STATUS_CTRL) |=> !AXI_RSP.rdata[B_CRST])
      else $error("counter reset bit reads one");
   ch1_bit5_a: assert property (rd_at(IDX_CH1_CTRL) |=> !AXI_RSP.rdata[B_BUF])
      else $error("channel 1 bit 5 reads one");
   reset_quiet_a: assert property ($fell(RST) |-> PINS == '0 && !TIMER_IRQ)
      else $error("outputs active after reset");
endmodule : tcct_timer_assertions

bind tcct_timer tcct_timer_assertions i_chk (.CLK(CLK), .RST(RST), .AXI_REQ(AXI_REQ),
   .AXI_RSP(AXI_RSP), .CH0_PIN_IN(CH0_PIN_IN), .CH1_PIN_IN(CH1_PIN_IN),
   .EXT_COUNT_CLOCK_PIN(EXT_COUNT_CLOCK_PIN), .PINS(PINS), .TIMER_IRQ(TIMER_IRQ));

/* File: tcct_timer_tb.sv */
`timescale 1ns/1ps
module tcct_timer_tb;
   import tcct_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   tcct_axi_req_t req = '0;
   tcct_axi_rsp_t rsp;
   tcct_pins_t pins;
   logic ch0_in;
   logic ch1_in;
   logic ext_clk;
   logic irq;
   logic ev0 = 1'b0;
   logic ev1 = 1'b0;
   int err_count = 0;
   int total_checks = 0;
   logic [7:0] d;
   logic [7:0] c;

   always #2 clk = ~clk;

   tcct_timer i_dut (.CLK(clk), .RST(rst), .AXI_REQ(req), .AXI_RSP(rsp), .CH0_PIN_IN(ch0_in),
      .CH1_PIN_IN(ch1_in), .EXT_COUNT_CLOCK_PIN(ext_clk), .PINS(pins), .TIMER_IRQ(irq));
   tcct_pin_model i_pins (.clk(clk), .pins(pins), .ev0(ev0), .ev1(ev1), .ch0_in(ch0_in),
      .ch1_in(ch1_in), .ext_clk(ext_clk));

   task automatic wrap_up;
      $display("Checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up

   task automatic bad(input string m);
      err_count++;
      $display("Error at %0t: %s", $time, m);
   endtask : bad

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) bad($sformatf("got %h want %h", got, exp));
   endtask : chk

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      total_checks++;
      if (got !== exp) bad($sformatf("resp %h want %h", got, exp));
   endtask : chk_resp

   task automatic limit(input int n);
      if (n < 100) return;
      bad("bus timeout");
      wrap_up();
   endtask : limit

   task automatic wr(input logic [5:0] idx, input logic [7:0] v, input logic [1:0] er = 2'h0,
      input logic [3:0] strb = 4'hf);
      bit a;
      bit w;
      int n;
      a = 1'b0;
      w = 1'b0;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= {idx, 2'b00};
      req.wvalid <= 1'b1;
      req.wdata <= {24'h000000, v};
      req.wstrb <= strb;
      req.bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (!a && rsp.awready) begin
            a = 1'b1;
            req.awvalid <= 1'b0;
         end
         if (!w && rsp.wready) begin
            w = 1'b1;
            req.wvalid <= 1'b0;
         end
         if (rsp.bvalid) break;
      end
      limit(n);
      chk_resp(rsp.bresp, er);
      req.bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] idx, output logic [7:0] v, input logic [1:0] er = 2'h0);
      int n;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= {idx, 2'b00};
      req.rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) break;
      end
      limit(n);
      v = rsp.rdata[7:0];
      chk_resp(rsp.rresp, er);
      req.rready <= 1'b0;
   endtask : rd

   task automatic t_reset;
      rd(IDX_STATUS_CTRL, d);
      chk(d, STATUS_CTRL_RST);
      // Byte lane off: answered but must leave the limit untouched
      wr(IDX_MOD_LO, 8'h00, RESP_OKAY, 4'h0);
      rd(IDX_MOD_HI, d);
      chk(d, MOD_RST[15:8]);
      rd(IDX_MOD_LO, d);
      chk(d, MOD_RST[7:0]);
      wr(IDX_CH1_CTRL, 8'h3c);
      rd(IDX_CH1_CTRL, d);
      chk(d, 8'h1c);
      wr(IDX_CH1_CTRL, 8'h00);
      rd(6'h03, d, RESP_SLVERR);
      wr(6'h3f, 8'h55, RESP_SLVERR);
      wr(IDX_CNT_LO, 8'h55);
      rd(IDX_CNT_LO, d);
      chk(d, 8'h00);
   endtask : t_reset

   task automatic t_count;
      wr(IDX_MOD_HI, 8'h00);
      wr(IDX_MOD_LO, 8'h09);
      wr(IDX_STATUS_CTRL, 8'h00);
      repeat (30) @(posedge clk);
      wr(IDX_STATUS_CTRL, 8'h20);
      rd(IDX_CNT_HI, d);
      chk(d, 8'h00);
      rd(IDX_CNT_LO, c);
      chk(8'(c > 8'h09), 8'h00);
      rd(IDX_CNT_LO, d);
      chk(d, c);
      rd(IDX_STATUS_CTRL, d);
      chk(d, 8'ha0);
      wr(IDX_STATUS_CTRL, 8'he0);
      chk({7'h0, irq}, 8'h01);
      wr(IDX_STATUS_CTRL, 8'h30);
      rd(IDX_STATUS_CTRL, d);
      chk(d, 8'h20);
      rd(IDX_CNT_LO, d);
      chk(d, 8'h00);
      wr(IDX_STATUS_CTRL, 8'h07);
      i_pins.ext_burst(5);
      repeat (6) @(posedge clk);
      rd(IDX_CNT_LO, d);
      chk(d, 8'h05);
      // Select 6: one count per 64 clocks, first one well after the read
      wr(IDX_STATUS_CTRL, 8'h16);
      rd(IDX_CNT_LO, d);
      chk(d, 8'h00);
      repeat (70) @(posedge clk);
      rd(IDX_CNT_LO, d);
      chk(d, 8'h01);
   endtask : t_count

   task automatic t_capture;
      wr(IDX_STATUS_CTRL, 8'h17);
      c = 8'h00;
      for (int e = 1; e <= 3; e++) begin
         rd(IDX_CH0_CTRL, d);
         wr(IDX_CH0_CTRL, 8'h40 | 8'(e << 2));
         i_pins.ext_burst(1);
         @(posedge clk);
         ev0 <= 1'b1;
         repeat (8) @(posedge clk);
         i_pins.ext_burst(1);
         @(posedge clk);
         ev0 <= 1'b0;
         repeat (8) @(posedge clk);
         c = c + 8'h02;
         rd(IDX_CH0_LO, d);
         chk(d, (e == 1) ? c - 8'h01 : c);
         rd(IDX_CH0_CTRL, d);
         chk(d, 8'hc0 | 8'(e << 2));
         chk({7'h0, irq}, 8'h01);
      end
      wr(IDX_CH0_CTRL, 8'h00);
      chk({7'h0, irq}, 8'h00);
      rd(IDX_CH1_CTRL, d);
      chk(d, 8'h00);
   endtask : t_capture

   task automatic t_compare;
      logic [1:0] act [3] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE};
      wr(IDX_CH1_HI, 8'h00);
      wr(IDX_CH1_LO, 8'h03);
      for (int i = 0; i < 3; i++) begin
         wr(IDX_CH1_CTRL, 8'h10 | {4'h0, act[i], 2'h0});
         wr(IDX_STATUS_CTRL, 8'h17);
         i_pins.ext_burst(3);
         repeat (6) @(posedge clk);
         if (i == 0) chk({6'h0, pins.oe[1], pins.out[1]}, 8'h02);
         i_pins.ext_burst(1);
         repeat (6) @(posedge clk);
         chk({6'h0, pins.oe[1], pins.out[1]}, {7'h01, i != 1});
      end
      wr(IDX_CH1_CTRL, 8'h1e);
      wr(IDX_STATUS_CTRL, 8'h17);
      i_pins.ext_burst(10);
      repeat (6) @(posedge clk);
      chk({7'h0, pins.out[1]}, 8'h00);
      rd(IDX_STATUS_CTRL, d);
      chk(d, 8'h87);
      // Full duty keeps the pin where the wrap toggle left it
      wr(IDX_CH1_CTRL, 8'h1d);
      wr(IDX_STATUS_CTRL, 8'h17);
      i_pins.ext_burst(4);
      repeat (6) @(posedge clk);
      chk({7'h0, pins.out[1]}, 8'h00);
   endtask : t_compare

   task automatic t_link;
      // Channel 0 compares at 2 until the first wrap, then at the channel 1 value 6
      wr(IDX_CH0_LO, 8'h02);
      wr(IDX_CH1_LO, 8'h06);
      wr(IDX_CH0_CTRL, 8'h2a);
      wr(IDX_STATUS_CTRL, 8'h17);
      i_pins.ext_burst(14);
      repeat (6) @(posedge clk);
      chk({6'h0, pins.oe[1], pins.out[0]}, 8'h01);
      i_pins.ext_burst(3);
      repeat (6) @(posedge clk);
      chk({7'h0, pins.out[0]}, 8'h00);
      wr(IDX_CH0_CTRL, 8'h00);
      wr(IDX_CH1_CTRL, 8'h44);
      wr(IDX_STATUS_CTRL, 8'h17);
      i_pins.ext_burst(2);
      ev1 <= 1'b1;
      repeat (8) @(posedge clk);
      rd(IDX_CH1_LO, d);
      chk(d, 8'h02);
      chk({7'h0, irq}, 8'h01);
      rd(IDX_CH1_CTRL, d);
      chk(d, 8'hc4);
      wr(IDX_CH1_CTRL, 8'h00);
      chk({7'h0, irq}, 8'h00);
      ev1 <= 1'b0;
   endtask : t_link

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_count();
      t_capture();
      t_compare();
      t_link();
      wrap_up();
   end
endmodule : tcct_timer_tb
